// [logic/wwd_cfg.svh]
`ifndef WWD_CFG_SVH
`define WWD_CFG_SVH
// ********************************************
// counter geometry
// ********************************************
`define WWD_CNT_W        18
`define WWD_CNT_MAX      18'h3FFFF
// period for a load of zero, one past the counter top
`define WWD_PERIOD_FULL  19'h40000
// ********************************************
// reset values
// ********************************************
`define WWD_RST_CNT      18'h00000
`define WWD_RST_BASE     18'h00000
// thresholds that belong to the reset base of zero
`define WWD_RST_HALF     18'h20000
`define WWD_RST_WARN     18'h30000
`endif

// [logic/wwd_pkg.sv]
package wwd_pkg;
   // ********************************************
   // types
   // ********************************************
   // watchdog sequencer states
   typedef enum logic [0:0] {
      WWD_IDLE,
      WWD_RUN
   } wwd_state_t;
endpackage

// [logic/wwd_thr_if.sv]
`timescale 1ns/100ps
`include "wwd_cfg.svh"
// ********************************************
// load capture and threshold carrier
// ********************************************
interface wwd_thr_if;
   logic                   ld_stb;   // capture a new load value
   logic [`WWD_CNT_W-1:0]  ld_val;   // load value to capture
   logic [`WWD_CNT_W-1:0]  base;     // load value in force
   logic [`WWD_CNT_W-1:0]  half_thr; // elapsed count opening the window
   logic [`WWD_CNT_W-1:0]  warn_thr; // elapsed count for early warning
   modport calc (input ld_stb, input ld_val, output base, output half_thr, output warn_thr);
   modport user (output ld_stb, output ld_val, input base, input half_thr, input warn_thr);
endinterface

// [logic/wwd_thresh.sv]
`timescale 1ns/100ps
`include "wwd_cfg.svh"
// ********************************************
// threshold calculator
// ********************************************
module wwd_thresh
   import wwd_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // carrier towards the sequencer
   wwd_thr_if.calc   thr
);
   logic [`WWD_CNT_W:0]   period;    // counts from load to overflow
   logic [`WWD_CNT_W-1:0] base_reg;  // captured load value
   logic [`WWD_CNT_W-1:0] base_next;
   logic [`WWD_CNT_W-1:0] half_reg;  // half of the period
   logic [`WWD_CNT_W-1:0] half_next;
   logic [`WWD_CNT_W-1:0] warn_reg;  // three quarters of the period
   logic [`WWD_CNT_W-1:0] warn_next;

   // thresholds worked out once per load, not per cycle,
   // so the compare path in the sequencer stays short
   always_comb
   begin
      period    = `WWD_PERIOD_FULL - {1'b0, thr.ld_val};
      base_next = base_reg;
      half_next = half_reg;
      warn_next = warn_reg;
      if (thr.ld_stb)
      begin
         base_next = thr.ld_val;
         half_next = period[`WWD_CNT_W:1];
         warn_next = `WWD_CNT_W'(period - {2'b00, period[`WWD_CNT_W:2]});
      end
   end

   // register stage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         base_reg <= `WWD_RST_BASE;
         half_reg <= `WWD_RST_HALF;
         warn_reg <= `WWD_RST_WARN;
      end
      else
      begin
         base_reg <= base_next;
         half_reg <= half_next;
         warn_reg <= warn_next;
      end
   end

   assign thr.base     = base_reg;
   assign thr.half_thr = half_reg;
   assign thr.warn_thr = warn_reg;
endmodule

// [logic/wwd_top.sv]
`timescale 1ns/100ps
`include "wwd_cfg.svh"
// Overview of operation
// - eighteen-bit up-counter starting from load value
// - counter advances on the system clock
// - feed before half period requests reset
// - reaching full timeout unfed requests reset
// - feed between half and full is valid
// - early warning at three quarters of period
module wwd_top
   import wwd_pkg::*;
#(
   parameter int CNT_W = `WWD_CNT_W
)
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // software control
   input  wire logic             wd_enable,
   input  wire logic [CNT_W-1:0] load_value,
   input  wire logic             feed,
   // watchdog results
   output logic                  sys_reset_req,
   output logic                  early_warn,
   output logic                  window_open,
   output logic                  running,
   output logic [CNT_W-1:0]      count
);
   // ********************************************
   // state
   // ********************************************
   wwd_state_t       state_reg;    // sequencer state
   wwd_state_t       state_next;
   logic [CNT_W-1:0] cnt_reg;      // watchdog count
   logic [CNT_W-1:0] cnt_next;
   logic             rst_req_reg;  // reset request pulse
   logic             rst_req_next;
   logic             warn_reg;     // early warning pulse
   logic             warn_next;
   logic             win_reg;      // refresh window is open
   logic             win_next;
   logic             running_reg;  // run state copy for the output pin
   logic             running_next;
   logic [CNT_W-1:0] elapsed_nx;   // elapsed count after increment

   wwd_thr_if thr ();

   // ********************************************
   // threshold unit
   // ********************************************
   wwd_thresh u_thresh
   (
      .clk (clk),
      .rst (rst),
      .thr (thr)
   );

   assign thr.ld_val = load_value;

   // half the period is zero only for a load at the counter top;
   // then the window stands open from the very first count
   function automatic logic win_at_load(input logic [CNT_W-1:0] ld);
      return &ld;
   endfunction

   // ********************************************
   // sequencer
   // ********************************************
   // next-state logic; feed is checked ahead of the timeout so a
   // refresh in the very last cycle still counts as valid
   always_comb
   begin
      state_next   = state_reg;
      cnt_next     = cnt_reg;
      rst_req_next = 1'b0;
      warn_next    = 1'b0;
      win_next     = win_reg;
      thr.ld_stb   = 1'b0;
      elapsed_nx   = CNT_W'(cnt_reg - thr.base + 1'b1);
      case (state_reg)
         WWD_IDLE:
         begin
            // idle: follow the load value, window shut
            cnt_next = load_value;
            win_next = 1'b0;
            if (wd_enable)
            begin
               state_next = WWD_RUN;
               thr.ld_stb = 1'b1;
               win_next   = win_at_load(load_value);
            end
         end
         WWD_RUN:
         begin
            if (!wd_enable)
            begin
               // disabled: stop and drop the window
               state_next = WWD_IDLE;
               win_next   = 1'b0;
            end
            else if (feed)
            begin
               rst_req_next = !win_reg;
               cnt_next   = load_value;
               thr.ld_stb = 1'b1;
               // a top load keeps the window open
               win_next   = win_at_load(load_value);
            end
            else if (cnt_reg == `WWD_CNT_MAX)
            begin
               rst_req_next = 1'b1;
               cnt_next     = load_value;
               thr.ld_stb   = 1'b1;
               win_next     = win_at_load(load_value);
            end
            else
            begin
               cnt_next  = CNT_W'(cnt_reg + 1'b1);
               win_next  = (elapsed_nx >= thr.half_thr);
               warn_next = (elapsed_nx == thr.warn_thr);
            end
         end
         default:
         begin
            state_next = WWD_IDLE;
            win_next   = 1'b0;
         end
      endcase
      // run flag registered so the pin comes from a flip-flop
      running_next = (state_next == WWD_RUN);
   end

   // register stage
   // runs on system clock
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg   <= WWD_IDLE;
         cnt_reg     <= `WWD_RST_CNT;
         rst_req_reg <= 1'b0;
         warn_reg    <= 1'b0;
         win_reg     <= 1'b0;
         running_reg <= 1'b0;
      end
      else
      begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         rst_req_reg <= rst_req_next;
         warn_reg    <= warn_next;
         win_reg     <= win_next;
         running_reg <= running_next;
      end
   end

   // ********************************************
   // outputs
   // ********************************************
   assign sys_reset_req = rst_req_reg;
   assign early_warn    = warn_reg;
   assign window_open   = win_reg;
   assign running       = running_reg;
   assign count         = cnt_reg;

   // ********************************************
   // checks
   // ********************************************
   // feed taken while running
   sequence s_feed_taken;
      (state_reg == WWD_RUN) && wd_enable && feed;
   endsequence

   // plain count step while running
   sequence s_step;
      (state_reg == WWD_RUN) && wd_enable && !feed && (cnt_reg != `WWD_CNT_MAX);
   endsequence

   AST_EARLY_FEED_RESET: assert property (@(posedge clk) disable iff (rst)
      s_feed_taken and !win_reg |=> sys_reset_req)
      else $error("early feed gave no reset");
   AST_VALID_FEED_QUIET: assert property (@(posedge clk) disable iff (rst)
      s_feed_taken and win_reg |=> !sys_reset_req)
      else $error("valid feed gave a reset");
   AST_TIMEOUT_RESET: assert property (@(posedge clk) disable iff (rst)
      (state_reg == WWD_RUN) && wd_enable && !feed && (cnt_reg == `WWD_CNT_MAX) |=> sys_reset_req)
      else $error("timeout gave no reset");
   AST_FEED_RELOADS: assert property (@(posedge clk) disable iff (rst)
      s_feed_taken |=> (count == $past(load_value)) && (thr.base == $past(load_value))
         && (window_open == (&$past(load_value))))
      else $error("feed did not restart from load");
   AST_COUNT_STEP: assert property (@(posedge clk) disable iff (rst)
      s_step |=> count == CNT_W'($past(count) + 1'b1))
      else $error("counter did not step by one");
   AST_COUNT_EVERY_CLOCK: assert property (@(posedge clk) disable iff (rst)
      s_step ##1 s_step |=> count == CNT_W'($past(count, 2) + 2'd2))
      else $error("counter skipped a clock");
   AST_WARN_POINT: assert property (@(posedge clk) disable iff (rst)
      early_warn |-> (CNT_W'(count - thr.base) == thr.warn_thr) && window_open && !sys_reset_req)
      else $error("warning off the three quarter point");
   AST_WARN_HIT: assert property (@(posedge clk) disable iff (rst)
      s_step and (elapsed_nx == thr.warn_thr) |=> early_warn ##1 !early_warn)
      else $error("three quarter point gave no single warning");

   // window level follows the half point on every plain step,
   // shut below it so an early feed is always caught
   AST_WINDOW_OPENS: assert property (@(posedge clk) disable iff (rst)
      s_step and (elapsed_nx >= thr.half_thr) |=> window_open)
      else $error("window shut past the half point");
   AST_WINDOW_SHUT: assert property (@(posedge clk) disable iff (rst)
      s_step and (elapsed_nx < thr.half_thr) |=> !window_open)
      else $error("window open before the half point");
endmodule

// [verification/tb_top.sv]
`timescale 1ns/100ps
`include "wwd_cfg.svh"
module tb_top;
   // ****
   // stimulus and observed ports
   // ****
   logic                  clk;           // system clock
   logic                  rst;           // sync reset
   logic                  wd_enable;     // run enable
   logic [`WWD_CNT_W-1:0] load_value;    // reload point
   logic                  feed;          // refresh request
   logic                  sys_reset_req; // reset pulse
   logic                  early_warn;    // warning pulse
   logic                  window_open;   // window level
   logic                  running;       // run state
   logic [`WWD_CNT_W-1:0] count;         // live count
   int                    fails;         // mismatches
   int                    checked;       // comparisons
   int                    cyc;           // hang guard
   // one row: load, elapsed at the deciding edge, feed or let it expire
   typedef struct {logic [17:0] ld; int e; bit fd;} wwd_row_t;
   wwd_row_t              rows [6];
   wwd_top #(.CNT_W(`WWD_CNT_W)) dut (.clk(clk), .rst(rst), .wd_enable(wd_enable),
      .load_value(load_value), .feed(feed), .sys_reset_req(sys_reset_req),
      .early_warn(early_warn), .window_open(window_open), .running(running), .count(count));
   // clock, 5 ns period
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard, ceiling well above the roughly 140 cycles needed
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 3000)
      begin
         fails = fails + 1;
         conclude();
      end
   end
   // ****
   // helpers
   // ****
   task automatic chk_bit(string nm, logic exp, logic got);
      checked = checked + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("MISMATCH %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task automatic chk_cnt(string nm, logic [17:0] exp, logic [17:0] got);
      checked = checked + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // inputs move 1 ns after the edge, outputs settled by then
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   // idle for one edge, then start from ld
   task automatic arm(logic [17:0] ld);
      wd_enable = 1'b0;
      load_value = ld;
      step();
      wd_enable = 1'b1;
      step();
      chk_bit("running", 1'b1, running);
   endtask
   // follow the count for n cycles, window and warning against elapsed
   task automatic walk(logic [17:0] ld, int n);
      int p;
      int h;
      int w;
      p = 2**18 - ld;
      h = p / 2;
      w = p - p / 4;
      for (int k = 0; k <= n; k++)
      begin
         chk_cnt("count", 18'(ld + k), count);
         chk_bit("window_open", k >= h, window_open);
         chk_bit("early_warn", k == w, early_warn);
         chk_bit("sys_reset_req", 1'b0, sys_reset_req);
         if (k < n)
            step();
      end
   endtask
   // deciding edge of one row, then pulse width and reload
   task automatic run_row(wwd_row_t r);
      int h;
      h = (2**18 - r.ld) / 2;
      arm(r.ld);
      walk(r.ld, r.e);
      feed = r.fd;
      step();
      feed = 1'b0;
      chk_bit("sys_reset_req", !r.fd || r.e < h, sys_reset_req);
      chk_cnt("count", r.ld, count);
      chk_bit("window_open", 1'b0, window_open);
      step();
      chk_bit("sys_reset_req", 1'b0, sys_reset_req);
   endtask
   // verdict and end of run
   task automatic conclude();
      if (fails == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ****
   // main sequence
   // ****
   initial
   begin
      rst = 1'b1;
      wd_enable = 1'b0;
      load_value = '0;
      feed = 1'b0;
      fails = 0;
      checked = 0;
      cyc = 0;
      rows = '{'{18'h3FFF0, 4, 1}, '{18'h3FFF0, 7, 1}, '{18'h3FFF0, 8, 1},
               '{18'h3FFF0, 15, 1}, '{18'h3FFF0, 15, 0}, '{18'h3FFE0, 25, 1}};
      repeat (8) step();
      chk_bit("running", 1'b0, running);
      rst = 1'b0;
      foreach (rows[i])
         run_row(rows[i]);
      // feed in window then again at once: window shut after reload
      arm(18'h3FFF0);
      walk(18'h3FFF0, 8);
      feed = 1'b1;
      step();
      chk_bit("sys_reset_req", 1'b0, sys_reset_req);
      step();
      feed = 1'b0;
      chk_bit("sys_reset_req", 1'b1, sys_reset_req);
      // load at the top: window open from the start, held feed is valid
      arm(18'h3FFFF);
      feed = 1'b1;
      repeat (2)
      begin
         step();
         chk_bit("sys_reset_req", 1'b0, sys_reset_req);
         chk_cnt("count", 18'h3FFFF, count);
         chk_bit("window_open", 1'b1, window_open);
      end
      // feed while disabled is ignored
      wd_enable = 1'b0;
      step();
      step();
      feed = 1'b0;
      chk_bit("running", 1'b0, running);
      chk_bit("sys_reset_req", 1'b0, sys_reset_req);
      // reset in mid-run clears everything
      arm(18'h3FFF0);
      walk(18'h3FFF0, 10);
      rst = 1'b1;
      step();
      rst = 1'b0;
      chk_bit("running", 1'b0, running);
      chk_bit("window_open", 1'b0, window_open);
      chk_cnt("count", 18'h00000, count);
      conclude();
   end
endmodule
